// ### design/cmpc_consts.vh
// Constants for the CAN mode and power control block.
`ifndef CMPC_CONSTS_VH
`define CMPC_CONSTS_VH
// ==========================================================
// Register word offsets (byte address = 4 x index).
`define CMPC_REG_CTL0 4'h0
`define CMPC_REG_CTL1 4'h1
`define CMPC_REG_BTR0 4'h2
`define CMPC_REG_BTR1 4'h3
`define CMPC_REG_ACC 4'h4
`define CMPC_REG_STAT 4'h5
`define CMPC_REG_FLAGS 4'h6
// ==========================================================
// Control register 0 bit positions.
`define CMPC_C0_INIT_REQUEST 0
`define CMPC_C0_SLEEP_REQUEST 1
`define CMPC_C0_WAKEUP_ENABLE 2
`define CMPC_C0_TXREQ 3
`define CMPC_C0_ABORT 4
// Control register 1 bit positions.
`define CMPC_C1_ENABLE 7
`define CMPC_C1_LISTEN 4
`define CMPC_C1_WAKEUP_FILTER_MODE 2
`define CMPC_C1_WAKEUP_IRQ_ENABLE 1
// Flags register bits (write one to clear).
`define CMPC_F_WAKE 0
`define CMPC_F_RXF 1
// ==========================================================
// Reset values.
`define CMPC_CTL0_RST 8'h01
`define CMPC_CTL1_RST 8'h00
`define CMPC_BTR_RST 8'h00
// ==========================================================
// Timing counts.
`define CMPC_SYNC_CYC 4'h3
`define CMPC_RECOV_CYC 8'h10
`define CMPC_IDLE_BITS 4'hb
`define CMPC_FILT_CYC 4'h8
`endif

// ### design/cmpc_sync.v
// Two flip-flop level synchroniser into the protocol domain enable.
`timescale 1ns/10ps
`default_nettype none
module cmpc_sync (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Enable of the receiving domain.
  input wire en_i,
  // Level in and out.
  input wire d_i,
  output reg q_o
);
  // ==========================================================
  // First stage, read only by the second stage.
  reg s1_q;
  // Both stages advance on the domain enable only.
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      q_o <= 1'b0;
    end else if (en_i) begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule
`default_nettype wire

// ### design/cmpc_top.v
// CAN mode and power control with an Avalon-MM register slave.
`timescale 1ns/10ps
`default_nettype none
`include "cmpc_consts.vh"
module cmpc_top #(
  parameter CAN_DIV = 4
) (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Avalon-MM slave.
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // Processor modes and special mode strap.
  input wire cpu_wait_i,
  input wire cpu_stop_i,
  input wire special_mode_i,
  // Protocol layer status.
  input wire tx_pending_i,
  input wire rx_busy_i,
  input wire bus_idle_i,
  input wire rx_frame_done_i,
  input wire proto_tx_i,
  // CAN pins.
  input wire rx_line_i,
  output reg tx_line_o,
  // Protocol layer controls.
  output reg proto_rx_o,
  output reg proto_clk_en_o,
  output reg proto_run_o,
  output reg proto_abort_o,
  output reg tx_start_o,
  output reg rx_shift_en_o,
  output reg busoff_count_en_o,
  output reg wake_irq_o
);
  // ==========================================================
  // Mode states, one-hot.
  localparam [6:0] ST_DIS = 7'h01;
  localparam [6:0] ST_INIT = 7'h02;
  localparam [6:0] ST_RUN = 7'h04;
  localparam [6:0] ST_SLPW = 7'h08;
  localparam [6:0] ST_SLP = 7'h10;
  localparam [6:0] ST_PD = 7'h20;
  localparam [6:0] ST_SYNC = 7'h40;
  // Registers.
  reg [7:0] ctl0_q; // Control register 0.
  reg [7:0] ctl1_q; // Control register 1.
  reg [7:0] btr0_q; // Bit timing register 0.
  reg [7:0] btr1_q; // Bit timing register 1.
  reg [7:0] acc_q; // Acceptance control.
  reg [1:0] flags_q; // Wake and receive full flags.
  reg en_locked_q; // Enable written once in normal modes.
  reg [6:0] st_q; // Mode state.
  reg init_ack_q; // Init acknowledge.
  reg slp_ack_q; // Sleep acknowledge.
  reg slept_q; // Was asleep before power-down.
  reg [7:0] cnt_q; // Delay and bit counter.
  reg [7:0] div_q; // CAN clock divider.
  reg pd_refuse_q; // Register access refused in power-down.
  reg [7:0] rcv_q; // Recovery ticks left after an unplanned power-down.
  wire can_tick;
  wire init_sync;
  wire init_sync_can;
  wire activity;
  wire wakeup_enable;
  wire listen;
  wire pd_cond;
  wire acc;
  wire wr;
  wire init_mode;
  wire sleeping;
  wire active;
  // ==========================================================
  // Decoded controls.
  assign wakeup_enable = ctl0_q[`CMPC_C0_WAKEUP_ENABLE];
  assign listen = ctl1_q[`CMPC_C1_LISTEN];
  assign init_mode = ctl0_q[`CMPC_C0_INIT_REQUEST] && init_ack_q;
  assign sleeping = st_q == ST_SLP;
  // The protocol engine runs in normal mode and while draining toward sleep.
  assign active = (st_q == ST_RUN) || (st_q == ST_SLPW);
  assign pd_cond = cpu_stop_i || (cpu_wait_i && ctl0_q[6]);
  assign acc = avs_read_i || avs_write_i;
  assign wr = avs_write_i && !avs_waitrequest_o && !pd_refuse_q;
  // ==========================================================
  // CAN clock enable divider, gated when disabled or powered down.
  always @(posedge clk_i) begin
    if (rst_i || div_q == CAN_DIV[7:0] - 8'h1) begin
      div_q <= 8'h0;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end
  assign can_tick = (div_q == 8'h0) && (st_q != ST_DIS) && (st_q != ST_PD);
  // Init request into the bus and CAN domains.
  cmpc_sync u_sync_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(1'b1),
    .d_i(ctl0_q[`CMPC_C0_INIT_REQUEST]),
    .q_o(init_sync)
  );
  cmpc_sync u_sync_can (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(can_tick),
    .d_i(init_sync),
    .q_o(init_sync_can)
  );
  // Wake-up activity, masked when wake-up disabled.
  cmpc_wake_filter u_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .filter_i(ctl1_q[`CMPC_C1_WAKEUP_FILTER_MODE]),
    .rx_i(rx_line_i || !wakeup_enable),
    .act_o(activity)
  );
  // ==========================================================
  // Mode state machine.
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_DIS;
      init_ack_q <= 1'b0;
      slp_ack_q <= 1'b0;
      slept_q <= 1'b0;
      cnt_q <= 8'h0;
      rcv_q <= 8'h0;
    end else begin
      // Init acknowledge follows the request once all domains agree; the
      // extra CAN tick gives the protocol domain its third clock to settle.
      if (init_sync_can && can_tick && init_sync && ctl0_q[`CMPC_C0_INIT_REQUEST]) begin
        init_ack_q <= 1'b1;
      end else if (!ctl0_q[`CMPC_C0_INIT_REQUEST]) begin
        init_ack_q <= 1'b0;
      end
      case (st_q)
        ST_DIS: begin
          if (ctl1_q[`CMPC_C1_ENABLE]) begin
            st_q <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (pd_cond) begin
            slept_q <= 1'b0;
            st_q <= ST_PD;
          end else if (!ctl0_q[`CMPC_C0_INIT_REQUEST]) begin
            cnt_q <= 8'h0;
            rcv_q <= 8'h0;
            st_q <= ST_SYNC;
          end
        end
        ST_RUN: begin
          if (pd_cond) begin
            slept_q <= 1'b0;
            st_q <= ST_PD;
          end else if (ctl0_q[`CMPC_C0_INIT_REQUEST]) begin
            st_q <= ST_INIT;
          end else if (ctl0_q[`CMPC_C0_SLEEP_REQUEST]) begin
            cnt_q <= 8'h0;
            st_q <= ST_SLPW;
          end
        end
        ST_SLPW: begin
          // Enter sleep once idle and the fixed delay has run.
          if (pd_cond) begin
            slept_q <= 1'b0;
            st_q <= ST_PD;
          end else if (!tx_pending_i && !rx_busy_i && bus_idle_i) begin
            if (cnt_q >= {4'h0, `CMPC_SYNC_CYC}) begin
              slp_ack_q <= 1'b1;
              st_q <= ST_SLP;
            end else begin
              cnt_q <= cnt_q + 8'h1;
            end
          end
        end
        ST_SLP: begin
          if (pd_cond) begin
            slept_q <= 1'b1;
            st_q <= ST_PD;
          end else if (activity || !ctl0_q[`CMPC_C0_SLEEP_REQUEST]) begin
            slp_ack_q <= 1'b0;
            cnt_q <= 8'h0;
            st_q <= ST_SYNC;
          end else if (ctl0_q[`CMPC_C0_INIT_REQUEST]) begin
            st_q <= ST_INIT;
          end
        end
        ST_PD: begin
          // Power-up runs a recovery, or skips it if asleep before, then waits for idle.
          if (!pd_cond) begin
            // An unplanned power-down costs a fixed recovery before idle counting.
            cnt_q <= 8'h0;
            rcv_q <= slept_q ? 8'h0 : `CMPC_RECOV_CYC;
            slp_ack_q <= 1'b0;
            st_q <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          // Wait for eleven recessive bits before joining.
          if (pd_cond) begin
            st_q <= ST_PD;
          end else if (ctl0_q[`CMPC_C0_INIT_REQUEST]) begin
            st_q <= ST_INIT;
          end else if (can_tick && rcv_q != 8'h0) begin
            // Recovery ticks run down first, whatever the line does.
            rcv_q <= rcv_q - 8'h1;
          end else if (can_tick) begin
            if (!rx_line_i) begin
              cnt_q <= (cnt_q > {4'h0, `CMPC_IDLE_BITS}) ? cnt_q - 8'h1 : 8'h0;
            end else if (cnt_q >= {4'h0, `CMPC_IDLE_BITS}) begin
              cnt_q <= 8'h0;
              st_q <= ST_RUN;
            end else begin
              cnt_q <= cnt_q + 8'h1;
            end
          end
        end
        default: st_q <= ST_DIS;
      endcase
    end
  end
  // ==========================================================
  // Register file with init and special-mode write locks.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl0_q <= `CMPC_CTL0_RST;
      ctl1_q <= `CMPC_CTL1_RST;
      btr0_q <= `CMPC_BTR_RST;
      btr1_q <= `CMPC_BTR_RST;
      acc_q <= `CMPC_BTR_RST;
      flags_q <= 2'b00;
      en_locked_q <= 1'b0;
    end else begin
      if (init_mode) begin
        ctl0_q[7:3] <= 5'h0;
        flags_q[`CMPC_F_RXF] <= 1'b0;
      end else if (rx_frame_done_i && rx_shift_en_o) begin
        flags_q[`CMPC_F_RXF] <= 1'b1;
      end else if (wr && avs_address_i == `CMPC_REG_FLAGS && avs_writedata_i[1]) begin
        flags_q[`CMPC_F_RXF] <= 1'b0;
      end
      // Wake flag: set wins over clear; power-down counts only if asleep before it.
      if (activity && wakeup_enable && (sleeping || (st_q == ST_PD && slept_q))) begin
        flags_q[`CMPC_F_WAKE] <= 1'b1;
      end else if (wr && avs_address_i == `CMPC_REG_FLAGS && avs_writedata_i[0]) begin
        flags_q[`CMPC_F_WAKE] <= 1'b0;
      end
      // Waking on bus activity withdraws the sleep request, so sleep is not re-entered.
      if (activity && sleeping) begin
        ctl0_q[`CMPC_C0_SLEEP_REQUEST] <= 1'b0;
      end
      if (wr) begin
        case (avs_address_i)
          `CMPC_REG_CTL0: begin
            // Request clears ignored until acknowledged.
            ctl0_q[`CMPC_C0_INIT_REQUEST] <= avs_writedata_i[0] || (!init_ack_q && ctl0_q[0]);
            ctl0_q[`CMPC_C0_SLEEP_REQUEST] <= avs_writedata_i[1] || (!slp_ack_q && ctl0_q[1]);
            ctl0_q[7:2] <= init_mode ? ctl0_q[7:2] : avs_writedata_i[7:2];
          end
          `CMPC_REG_CTL1: begin
            if (init_mode || special_mode_i) begin
              ctl1_q[6:0] <= avs_writedata_i[6:0];
            end
            if (!en_locked_q || special_mode_i) begin
              ctl1_q[7] <= avs_writedata_i[7];
              en_locked_q <= !special_mode_i;
            end
          end
          `CMPC_REG_BTR0: begin
            if (init_mode || special_mode_i) btr0_q <= avs_writedata_i[7:0];
          end
          `CMPC_REG_BTR1: begin
            if (init_mode || special_mode_i) btr1_q <= avs_writedata_i[7:0];
          end
          `CMPC_REG_ACC: begin
            if (init_mode || special_mode_i) acc_q <= avs_writedata_i[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end
  // ==========================================================
  // Avalon answer: one wait cycle, refused access reads zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      pd_refuse_q <= 1'b0;
    end else begin
      pd_refuse_q <= st_q == ST_PD;
      avs_waitrequest_o <= !(acc && avs_waitrequest_o);
      avs_readdata_o <= 32'h0000_0000;
      if (avs_read_i && avs_waitrequest_o && st_q != ST_PD) begin
        case (avs_address_i)
          `CMPC_REG_CTL0: avs_readdata_o <= {24'h0, ctl0_q};
          `CMPC_REG_CTL1: avs_readdata_o <= {24'h0, ctl1_q};
          `CMPC_REG_BTR0: avs_readdata_o <= {24'h0, btr0_q};
          `CMPC_REG_BTR1: avs_readdata_o <= {24'h0, btr1_q};
          `CMPC_REG_ACC: avs_readdata_o <= {24'h0, acc_q};
          `CMPC_REG_STAT: avs_readdata_o <= {25'h0, st_q == ST_PD, slp_ack_q, init_ack_q,
                                             st_q[3:0] == 4'h0 ? 4'h0 : st_q[3:0]};
          `CMPC_REG_FLAGS: avs_readdata_o <= {30'h0, flags_q};
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ==========================================================
  // Protocol-side outputs, all registered.
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_line_o <= 1'b1;
      proto_rx_o <= 1'b1;
      proto_clk_en_o <= 1'b0;
      proto_run_o <= 1'b0;
      proto_abort_o <= 1'b0;
      tx_start_o <= 1'b0;
      rx_shift_en_o <= 1'b0;
      busoff_count_en_o <= 1'b0;
      wake_irq_o <= 1'b0;
    end else begin
      // Line recessive unless running and not listen-only.
      tx_line_o <= (active && !listen && !init_mode) ? proto_tx_i : 1'b1;
      // Listen-only folds own dominant bits into receive path.
      proto_rx_o <= sleeping ? (rx_line_i || !wakeup_enable) :
                    (listen ? (rx_line_i && proto_tx_i) : rx_line_i);
      proto_clk_en_o <= can_tick && !sleeping;
      proto_run_o <= active;
      proto_abort_o <= (st_q == ST_INIT || st_q == ST_PD) ||
                       (st_q == ST_RUN && ctl0_q[`CMPC_C0_ABORT]);
      tx_start_o <= active && !listen && ctl0_q[`CMPC_C0_TXREQ];
      rx_shift_en_o <= active;
      busoff_count_en_o <= st_q == ST_RUN || st_q == ST_SYNC;
      wake_irq_o <= flags_q[`CMPC_F_WAKE] && wakeup_enable && ctl1_q[`CMPC_C1_WAKEUP_IRQ_ENABLE];
    end
  end
endmodule
`default_nettype wire

// ### design/cmpc_wake_filter.v
// Bus activity detector with optional low-pass glitch filter.
`timescale 1ns/10ps
`default_nettype none
`include "cmpc_consts.vh"
module cmpc_wake_filter (
  // Clock and reset.
  input wire clk_i,
  input wire rst_i,
  // Filter select and receive input.
  input wire filter_i,
  input wire rx_i,
  // Activity pulse.
  output reg act_o
);
  // ==========================================================
  // Count of consecutive dominant samples.
  reg [3:0] cnt_q;
  // A dominant level counts; filtered mode needs a held level.
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      act_o <= 1'b0;
    end else begin
      if (rx_i) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1;
      end
      act_o <= !rx_i && (filter_i ? (cnt_q >= `CMPC_FILT_CYC) : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ### dv/cmpc_bus_model.sv
// Wired-AND CAN bus with other nodes that send dominant bursts on request.
`timescale 1ns/10ps
`default_nettype none
module cmpc_bus_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Burst request from the bench and our transmit line.
  input wire logic go_i,
  input wire logic [7:0] len_i,
  input wire logic tx_i,
  // Resolved bus level seen by the receiver.
  output logic rx_o
);
  logic [7:0] cnt_q; // Dominant cycles still to send.
  // A burst loads the counter; the bus pulls up to recessive when nobody drives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else if (go_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign rx_o = tx_i & (cnt_q == 8'h00);
endmodule
`default_nettype wire

// ### dv/cmpc_monitor.sv
// Port checker for the CAN mode and power control block.
`timescale 1ns/10ps
`default_nettype none
module cmpc_monitor #(
  parameter CAN_DIV = 4
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus.
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Modes, pins and protocol controls.
  input wire logic cpu_stop_i,
  input wire logic rx_line_i,
  input wire logic tx_line_o,
  input wire logic proto_run_o,
  input wire logic tx_start_o,
  input wire logic rx_shift_en_o,
  input wire logic wake_irq_o
);
  // ==========================================================
  // Helper counters.
  logic [7:0] rec_q; // Consecutive recessive cycles, saturating.
  logic [7:0] dom_q; // Cycles since the line was last dominant, saturating.
  // The counters follow the receive pin every cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_q <= 8'h00;
      dom_q <= 8'hff;
    end else begin
      rec_q <= !rx_line_i ? 8'h00 : (rec_q == 8'hff ? rec_q : rec_q + 8'h01);
      dom_q <= !rx_line_i ? 8'h00 : (dom_q == 8'hff ? dom_q : dom_q + 8'h01);
    end
  end
  // ==========================================================
  // Properties.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_state_a: assert property ($fell(rst_i) |-> tx_line_o && avs_waitrequest_o && !proto_run_o)
    else $error("state after reset is wrong");
  stopped_recessive_a: assert property (!proto_run_o && $past(!proto_run_o) |-> tx_line_o)
    else $error("transmit line dominant while stopped");
  stop_pdown_a: assert property (cpu_stop_i [*4] |-> !proto_run_o)
    else $error("protocol still running in processor stop");
  pdown_read_a: assert property (cpu_stop_i [*4] ##0 (avs_read_i && !avs_waitrequest_o) |-> avs_readdata_o == 32'h0000_0000)
    else $error("register read answered in power-down");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait");
  idle_data_a: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0000_0000)
    else $error("read data outside a completion");
  start_needs_run_a: assert property (tx_start_o |-> proto_run_o)
    else $error("transmission started while stopped");
  shift_needs_run_a: assert property (rx_shift_en_o |-> proto_run_o)
    else $error("receive shift allowed while stopped");
  rejoin_idle_a: assert property ($rose(proto_run_o) |-> rec_q >= 10 * CAN_DIV)
    else $error("joined the bus without eleven recessive bits");
  wake_cause_a: assert property ($rose(wake_irq_o) |-> dom_q < 8'd40)
    else $error("wake interrupt without bus activity");
  cover property ($rose(wake_irq_o));
  cover property (cpu_stop_i [*4]);
  cover property ($rose(proto_run_o));
endmodule
bind cmpc_top cmpc_monitor #(.CAN_DIV(CAN_DIV)) cmpc_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .cpu_stop_i(cpu_stop_i), .rx_line_i(rx_line_i),
  .tx_line_o(tx_line_o), .proto_run_o(proto_run_o), .tx_start_o(tx_start_o),
  .rx_shift_en_o(rx_shift_en_o), .wake_irq_o(wake_irq_o));
`default_nettype wire

// ### dv/cmpc_tb.sv
// Self-checking bench for the CAN mode and power control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, go;
  logic [3:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic cpu_wait_i, cpu_stop_i, special_mode_i, tx_pending_i, rx_busy_i, bus_idle_i;
  logic proto_tx_i, rx_line_i, tx_line_o, proto_rx_o, proto_clk_en_o, proto_run_o;
  logic proto_abort_o, tx_start_o, rx_shift_en_o, busoff_count_en_o, wake_irq_o, rx_frame_done_i;
  logic [7:0] len;
  int n_fail, n_checks;
  cmpc_top #(.CAN_DIV(4)) cmpc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .cpu_wait_i(cpu_wait_i), .cpu_stop_i(cpu_stop_i),
    .special_mode_i(special_mode_i), .tx_pending_i(tx_pending_i), .rx_busy_i(rx_busy_i),
    .bus_idle_i(bus_idle_i), .rx_frame_done_i(rx_frame_done_i), .proto_tx_i(proto_tx_i),
    .rx_line_i(rx_line_i), .tx_line_o(tx_line_o), .proto_rx_o(proto_rx_o),
    .proto_clk_en_o(proto_clk_en_o), .proto_run_o(proto_run_o), .proto_abort_o(proto_abort_o),
    .tx_start_o(tx_start_o), .rx_shift_en_o(rx_shift_en_o),
    .busoff_count_en_o(busoff_count_en_o), .wake_irq_o(wake_irq_o));
  cmpc_bus_model cmpc_bus_model_inst (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(len),
    .tx_i(tx_line_o), .rx_o(rx_line_i));
  // ==========================================================
  // Clock, closing task and shared helpers.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One Avalon cycle: hold everything until waitrequest is sampled low.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", avs_waitrequest_o, 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // Reads the status word until the chosen bit reaches the wanted level.
  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h5, 32'h0000_0000);
      n++;
    end while (rd[b] !== v && n < 60);
    chk("status bit", rd[b], v);
  endtask
  task wait_run(input logic v);
    int n;
    for (n = 0; n < 300 && proto_run_o !== v; n++) @(posedge clk_i);
    chk("run", proto_run_o, v);
  endtask
  // Asks the other nodes for a dominant burst and lets it pass.
  task burst(input logic [7:0] l);
    @(posedge clk_i);
    go <= 1'b1;
    len <= l;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (l + 8) @(posedge clk_i);
  endtask
  // Reports one received frame from the protocol layer.
  task frame;
    rx_frame_done_i <= 1'b1;
    @(posedge clk_i);
    rx_frame_done_i <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios.
  task s_reset;
    bus(1'b0, 4'h0, 0); chk("ctl0", rd, 32'h0000_0001);
    bus(1'b0, 4'h1, 0); chk("ctl1", rd, 32'h0000_0000);
    bus(1'b0, 4'h7, 0); chk("unmapped", rd, 32'h0000_0000);
    chk("tx", tx_line_o, 1'b1);
    chk("clk en", proto_clk_en_o, 1'b0);
  endtask
  task s_init;
    bus(1'b1, 4'h1, 32'h0000_0080);
    poll(4, 1'b1);
    chk("run", proto_run_o, 1'b0);
    bus(1'b1, 4'h1, 32'h0000_0086);
    bus(1'b1, 4'h2, 32'h0000_005a);
    bus(1'b0, 4'h2, 0); chk("btr0", rd, 32'h0000_005a);
    bus(1'b1, 4'h0, 32'h0000_0004);
    poll(4, 1'b0);
    wait_run(1'b1);
    frame;
    bus(1'b1, 4'h2, 32'h0000_0033);
    bus(1'b0, 4'h2, 0); chk("btr0 locked", rd, 32'h0000_005a);
    bus(1'b1, 4'h0, 32'h0000_0008);
    proto_tx_i <= 1'b0;
    tx_pending_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("tx normal", tx_line_o, 1'b0);
    chk("start normal", tx_start_o, 1'b1);
    proto_tx_i <= 1'b1;
  endtask
  task s_sleep;
    rx_busy_i <= 1'b1;
    bus_idle_i <= 1'b0;
    bus(1'b1, 4'h0, 32'h0000_0006);
    repeat (40) @(posedge clk_i);
    bus(1'b0, 4'h5, 0); chk("ack tx busy", rd[5], 1'b0);
    tx_pending_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    bus(1'b0, 4'h5, 0); chk("ack rx busy", rd[5], 1'b0);
    rx_busy_i <= 1'b0;
    bus_idle_i <= 1'b1;
    poll(5, 1'b1);
    chk("run", proto_run_o, 1'b0);
    chk("shift", rx_shift_en_o, 1'b0);
    chk("busoff", busoff_count_en_o, 1'b0);
    chk("tx", tx_line_o, 1'b1);
    bus(1'b0, 4'h6, 0); chk("rxf kept", rd[1], 1'b1);
    bus(1'b1, 4'h6, 32'h0000_0002);
    frame;
    bus(1'b0, 4'h6, 0); chk("rxf no shift", rd[1], 1'b0);
    burst(8'h02);
    bus(1'b0, 4'h5, 0); chk("glitch", rd[5], 1'b1);
    burst(8'h14);
    poll(5, 1'b0);
    chk("irq", wake_irq_o, 1'b1);
    bus(1'b1, 4'h6, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    chk("irq clr", wake_irq_o, 1'b0);
    bus(1'b1, 4'h0, 32'h0000_0004);
    wait_run(1'b1);
    bus(1'b1, 4'h0, 32'h0000_0002);
    poll(5, 1'b1);
    burst(8'h14);
    bus(1'b0, 4'h5, 0); chk("locked sleep", rd[5], 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0004);
    poll(5, 1'b0);
    wait_run(1'b1);
  endtask
  task s_pdown;
    cpu_wait_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("wait run", proto_run_o, 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0044);
    repeat (10) @(posedge clk_i);
    chk("wait pdown", proto_run_o, 1'b0);
    chk("tx", tx_line_o, 1'b1);
    cpu_wait_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk("recovery", proto_run_o, 1'b0);
    wait_run(1'b1);
    cpu_stop_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("stop run", proto_run_o, 1'b0);
    bus(1'b0, 4'h0, 0); chk("pdown read", rd, 32'h0000_0000);
    cpu_stop_i <= 1'b0;
    wait_run(1'b1);
  endtask
  task s_listen;
    bus(1'b1, 4'h0, 32'h0000_0045);
    bus(1'b1, 4'h0, 32'h0000_0044);
    bus(1'b0, 4'h0, 0); chk("init held", rd[0], 1'b1);
    poll(4, 1'b1);
    bus(1'b0, 4'h0, 0); chk("ctl0 init", rd[7:3], 5'h00);
    bus(1'b1, 4'h1, 32'h0000_0096);
    bus(1'b1, 4'h0, 32'h0000_0004);
    poll(4, 1'b0);
    wait_run(1'b1);
    bus(1'b1, 4'h0, 32'h0000_000c);
    proto_tx_i <= 1'b0;
    tx_pending_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("tx listen", tx_line_o, 1'b1);
    chk("loopback", proto_rx_o, 1'b0);
    chk("start listen", tx_start_o, 1'b0);
    proto_tx_i <= 1'b1;
    tx_pending_i <= 1'b0;
    special_mode_i <= 1'b1;
    bus(1'b1, 4'h2, 32'h0000_0033);
    bus(1'b0, 4'h2, 0); chk("btr0 special", rd, 32'h0000_0033);
  endtask
  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    {avs_read_i, avs_write_i, go, cpu_wait_i, cpu_stop_i, special_mode_i} = 6'h00;
    {tx_pending_i, rx_busy_i, rx_frame_done_i} = 3'b000;
    {bus_idle_i, proto_tx_i, rst_i} = 3'b111;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0000_0000;
    len = 8'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset;
    s_init;
    s_sleep;
    s_pdown;
    s_listen;
    report_and_stop;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
